// ---- include/ctos_pkg.sv ----
// package for calibration/test output select
// assumes one clock domain, synchronous reset
package ctos_pkg;
   // ------------------------------------------------------------
   // operating mode codes and configuration constants
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_CAL1    = 4'h1;
   localparam logic [3:0] MODE_CAL2    = 4'h2;
   localparam logic [3:0] MODE_CAL3    = 4'h7;
   localparam logic [3:0] MODE_TEST6   = 4'h6;
   localparam logic [3:0] MODE_SYSTEST = 4'hb;
   localparam logic [8:0] RES_SYSTEST  = 9'h1b0;
   localparam logic [3:0] HYS_SYSTEST  = 4'hf;
   localparam int         RES_STEPS    = 8;
   localparam int         SWITCH_DEG   = 360 / RES_STEPS;
   localparam int         SWITCH_PER_Q = 90 / SWITCH_DEG;
   localparam logic [1:0] BIAS_INTERNAL = 2'h0;
   localparam int         RIN_VOLT_BIT  = 0;
   localparam int         TOP_CHK_ON    = 3;
   localparam int         TOP_CHK_OFF   = 4;
   localparam int         OUT_CFG_HI    = 7;
   localparam int         OUT_CFG_LO    = 4;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic a_pos;
      logic a_neg;
      logic b_pos;
      logic b_neg;
      logic z_pos;
      logic z_neg;
      logic err;
   } ctos_pins_t;

   typedef struct packed {
      logic sin_pos;
      logic sin_neg;
      logic cos_pos;
      logic cos_neg;
      logic zero_chan_pos;
      logic zero_chan_neg;
      logic mid_potential_one;
      logic mid_potential_two;
      logic bias_current;
      logic temp_sense;
      logic temp_thresh;
      logic temp_warn;
      logic temp_shut;
   } ctos_analog_t;

   typedef enum logic [2:0] {
      CTOS_SRC_NORMAL,
      CTOS_SRC_CAL1,
      CTOS_SRC_CAL2,
      CTOS_SRC_CAL3,
      CTOS_SRC_TEST6,
      CTOS_SRC_SYSTEST
   } ctos_src_t;
endpackage

// ---- rtl/ctos_sync.sv ----
// three-stage input synchroniser with agreement filter
// assumes input asynchronous to ref_clk
`timescale 1ns/1ps
module ctos_sync
   import ctos_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] st1_ff;
   logic [WIDTH-1:0] st2_ff;
   logic [WIDTH-1:0] st3_ff;
   logic [WIDTH-1:0] out_ff;
   logic [WIDTH-1:0] nxt_out;

   // --------------------------------------------------------------
   // accept a change once stages two and three agree
   // --------------------------------------------------------------
   assign nxt_out  = (~(st2_ff ^ st3_ff) & st2_ff) | ((st2_ff ^ st3_ff) & out_ff);
   assign sync_out = out_ff;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st1_ff <= '0;
         st2_ff <= '0;
         st3_ff <= '0;
         out_ff <= '0;
      end else if (clk_en) begin
         st1_ff <= async_in;
         st2_ff <= st1_ff;
         st3_ff <= st2_ff;
         out_ff <= nxt_out;
      end
   end
endmodule

// ---- rtl/ctos_top.sv ----
// output pin multiplexer for calibration and system test modes
// assumes all source signals on ref_clk except the zero input pin
`timescale 1ns/1ps
module ctos_top
   import ctos_pkg::*;
#(
   parameter int ANGLE_W  = 3,
   parameter int COUNT_W  = 16
) (
   input  wire logic               ref_clk,
   input  wire logic               srst,
   input  wire logic               clk_en,
   input  wire logic [3:0]         mode_select,
   input  wire logic [8:0]         resolution_select,
   input  wire logic [3:0]         hysteresis_select,
   input  wire logic [7:0]         output_config,
   input  wire logic [5:0]         fine_gain_a,
   input  wire logic [5:0]         fine_gain_b,
   input  wire logic [7:0]         test_option_bits,
   input  wire logic [1:0]         input_reference_select,
   input  wire logic [3:0]         sincos_input_resistance,
   input  wire logic [3:0]         zero_input_resistance,
   input  wire logic               index_enable,
   input  wire logic [COUNT_W-1:0] lines_per_zero,
   input  wire logic [ANGLE_W-1:0] angle_octant,
   input  wire logic               zero_pin_raw,
   input  wire logic               error_in,
   input  wire ctos_pins_t         normal_pins,
   input  wire ctos_analog_t       analog_in,
   output ctos_pins_t              out_pins,
   output ctos_src_t               src_sel,
   output logic                    systest_setup_ok,
   output logic                    input_check_ok,
   output logic                    sincos_current_mode,
   output logic                    zero_current_mode,
   output logic                    reference_ok,
   output logic                    verify_done,
   output logic                    line_count_error
);
   // --------------------------------------------------------------
   // mode decode
   // --------------------------------------------------------------
   wire is_cal1    = (mode_select == MODE_CAL1);
   wire is_cal2    = (mode_select == MODE_CAL2);
   wire is_cal3    = (mode_select == MODE_CAL3);
   wire is_test6   = (mode_select == MODE_TEST6);
   wire is_systest = (mode_select == MODE_SYSTEST);

   ctos_src_t src_w;
   always_comb begin
      if (is_systest) begin
         src_w = CTOS_SRC_SYSTEST;
      end else if (is_cal1) begin
         src_w = CTOS_SRC_CAL1;
      end else if (is_cal2) begin
         src_w = CTOS_SRC_CAL2;
      end else if (is_cal3) begin
         src_w = CTOS_SRC_CAL3;
      end else if (is_test6) begin
         src_w = CTOS_SRC_TEST6;
      end else begin
         src_w = CTOS_SRC_NORMAL;
      end
   end

   // --------------------------------------------------------------
   // configuration checks
   // --------------------------------------------------------------
   wire setup_w = (resolution_select == RES_SYSTEST)
                & (hysteresis_select == HYS_SYSTEST)
                & (output_config[OUT_CFG_HI:OUT_CFG_LO] == '0);
   wire check_w = (fine_gain_a == '0) & (fine_gain_b == '0)
                & test_option_bits[TOP_CHK_ON]
                & ~test_option_bits[TOP_CHK_OFF];
   wire sc_cur_w = ~sincos_input_resistance[RIN_VOLT_BIT];
   wire z_cur_w  = ~zero_input_resistance[RIN_VOLT_BIT];
   wire ref_ok_w = ~(sc_cur_w | z_cur_w)
                 | (input_reference_select == BIAS_INTERNAL);

   // --------------------------------------------------------------
   // zero input synchroniser
   // --------------------------------------------------------------
   logic zero_sync;
   ctos_sync #(
      .WIDTH (1)
   ) u_zero_sync (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .async_in (zero_pin_raw),
      .sync_out (zero_sync)
   );

   // --------------------------------------------------------------
   // switchpoints from octant of the angle, 45 degree steps
   // --------------------------------------------------------------
   // octant 0..7: a4 = sine sign, b4 = cosine sign,
   // a8 toggles every 90 degrees at the odd octants, b8 toggles every 45 degrees
   wire [ANGLE_W-1:0] oct = angle_octant;
   wire a4_w = ~oct[ANGLE_W-1];
   wire b4_w = ~(oct[ANGLE_W-1] ^ oct[ANGLE_W-2]);
   wire a8_w = oct[0] ^ oct[ANGLE_W-2];
   wire b8_w = oct[0];

   // --------------------------------------------------------------
   // line count verification between zero pulses
   // --------------------------------------------------------------
   logic               zero_d_ff;
   logic [COUNT_W-1:0] cnt_ff;
   logic [1:0]         zeros_ff;
   logic               done_ff;
   logic               lerr_ff;
   logic [ANGLE_W-1:0] oct_d_ff;
   logic [COUNT_W-1:0] nxt_cnt;
   logic [1:0]         nxt_zeros;
   logic               nxt_done;
   logic               nxt_lerr;

   wire zero_rise = zero_sync & ~zero_d_ff;
   wire line_step = (oct != oct_d_ff) & (oct == '0);
   wire armed     = index_enable & is_systest;

   always_comb begin
      nxt_cnt   = cnt_ff;
      nxt_zeros = zeros_ff;
      nxt_done  = done_ff;
      nxt_lerr  = lerr_ff;
      if (!armed) begin
         nxt_cnt   = '0;
         nxt_zeros = '0;
         nxt_done  = 1'b0;
         nxt_lerr  = 1'b0;
      end else if (zero_rise) begin
         nxt_cnt = '0;
         if (zeros_ff != 2'h2) begin
            nxt_zeros = zeros_ff + 2'h1;
         end
         if (zeros_ff != 2'h0) begin
            nxt_done = 1'b1;
            nxt_lerr = (cnt_ff != lines_per_zero);
         end
      end else if (line_step) begin
         nxt_cnt = cnt_ff + {{(COUNT_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         zero_d_ff <= 1'b0;
         oct_d_ff  <= '0;
         cnt_ff    <= '0;
         zeros_ff  <= '0;
         done_ff   <= 1'b0;
         lerr_ff   <= 1'b0;
      end else if (clk_en) begin
         zero_d_ff <= zero_sync;
         oct_d_ff  <= oct;
         cnt_ff    <= nxt_cnt;
         zeros_ff  <= nxt_zeros;
         done_ff   <= nxt_done;
         lerr_ff   <= nxt_lerr;
      end
   end

   // error valid only once two zero pulses seen
   wire err_valid = done_ff & (error_in | lerr_ff);

   // --------------------------------------------------------------
   // output pin multiplexer
   // --------------------------------------------------------------
   ctos_pins_t pins_w;
   always_comb begin
      pins_w = normal_pins;
      case (src_w)
         CTOS_SRC_SYSTEST: begin
            pins_w.a_pos = a4_w;
            pins_w.b_pos = b4_w;
            pins_w.a_neg = a8_w;
            pins_w.b_neg = b8_w;
            pins_w.z_pos = zero_sync;
            pins_w.z_neg = done_ff;
            pins_w.err   = err_valid;
         end
         CTOS_SRC_CAL1: begin
            pins_w.a_pos = analog_in.bias_current;
            pins_w.z_pos = analog_in.zero_chan_pos;
            pins_w.z_neg = analog_in.zero_chan_neg;
         end
         CTOS_SRC_CAL2: begin
            pins_w.a_pos = analog_in.sin_pos;
            pins_w.a_neg = analog_in.sin_neg;
            pins_w.b_pos = analog_in.cos_pos;
            pins_w.b_neg = analog_in.cos_neg;
            pins_w.z_pos = analog_in.mid_potential_one;
            pins_w.z_neg = analog_in.mid_potential_two;
         end
         CTOS_SRC_CAL3: begin
            pins_w.a_pos = analog_in.temp_sense;
            pins_w.a_neg = analog_in.temp_thresh;
            pins_w.b_pos = 1'b0;
            pins_w.b_neg = 1'b0;
            pins_w.z_pos = analog_in.temp_warn;
            pins_w.z_neg = analog_in.temp_shut;
         end
         CTOS_SRC_TEST6: begin
            pins_w.a_pos = analog_in.sin_pos & check_w;
            pins_w.a_neg = analog_in.sin_neg & check_w;
            pins_w.b_pos = analog_in.cos_pos & check_w;
            pins_w.b_neg = analog_in.cos_neg & check_w;
            pins_w.z_pos = analog_in.mid_potential_one;
            pins_w.z_neg = analog_in.mid_potential_two;
         end
         default: begin
            pins_w = normal_pins;
         end
      endcase
   end

   // --------------------------------------------------------------
   // registered outputs
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_pins            <= '0;
         src_sel             <= CTOS_SRC_NORMAL;
         systest_setup_ok    <= 1'b0;
         input_check_ok      <= 1'b0;
         sincos_current_mode <= 1'b0;
         zero_current_mode   <= 1'b0;
         reference_ok        <= 1'b0;
      end else if (clk_en) begin
         out_pins            <= pins_w;
         src_sel             <= src_w;
         systest_setup_ok    <= setup_w;
         input_check_ok      <= check_w;
         sincos_current_mode <= sc_cur_w;
         zero_current_mode   <= z_cur_w;
         reference_ok        <= ref_ok_w;
      end
   end

   assign verify_done      = done_ff;
   assign line_count_error = lerr_ff;
endmodule

// ---- tb/ctos_enc_model.sv ----
// sensor-side model: angle octants and one zero pulse per LINES lines
// assumes a free-running ref_clk
`timescale 1ns/1ps
module ctos_enc_model #(
   parameter int LINES = 5
) (
   input  wire logic  ref_clk,
   input  wire logic  run,
   output logic [2:0] angle_octant,
   output logic       zero_pin
);
   logic [1:0] sub_ff  = 2'h0;
   logic [2:0] oct_ff  = 3'h0;
   int         line_ff = 0;
   // ----------------
   // octant every four clocks
   // ----------------
   always @(posedge ref_clk) begin
      if (run) begin
         sub_ff <= sub_ff + 2'h1;
         if (sub_ff == 2'h3) begin
            oct_ff <= oct_ff + 3'h1;
            if (oct_ff == 3'h7) begin
               line_ff <= (line_ff == LINES - 1) ? 0 : line_ff + 1;
            end
         end
      end
   end
   assign angle_octant = oct_ff;
   // zero mid-line, away from the octant wrap
   assign zero_pin     = run && line_ff == 0 && oct_ff == 3'h4;
endmodule

// ---- tb/ctos_top_sva.sv ----
// assertions on the output pin routing of ctos_top
// assumes one clock domain and a synchronous reset
`timescale 1ns/1ps
module ctos_top_sva
   import ctos_pkg::*;
#(
   parameter int ANGLE_W = 3,
   parameter int COUNT_W = 16
) (
   input wire logic               ref_clk,
   input wire logic               srst,
   input wire logic               clk_en,
   input wire logic [3:0]         mode_select,
   input wire logic [3:0]         sincos_input_resistance,
   input wire logic [3:0]         zero_input_resistance,
   input wire logic [ANGLE_W-1:0] angle_octant,
   input wire ctos_pins_t         normal_pins,
   input wire ctos_pins_t         out_pins,
   input wire ctos_src_t          src_sel,
   input wire logic               sincos_current_mode,
   input wire logic               zero_current_mode,
   input wire logic               verify_done
);
   default clocking cb_d @(posedge ref_clk); endclocking
   default disable iff (srst);
   ctos_src_t exp_src;
   logic      st;
   logic      en_st;
   assign st      = mode_select == MODE_SYSTEST;
   assign en_st   = !srst && clk_en && st;
   assign exp_src = st ? CTOS_SRC_SYSTEST :
                    (mode_select == MODE_CAL1) ? CTOS_SRC_CAL1 :
                    (mode_select == MODE_CAL2) ? CTOS_SRC_CAL2 :
                    (mode_select == MODE_CAL3) ? CTOS_SRC_CAL3 :
                    (mode_select == MODE_TEST6) ? CTOS_SRC_TEST6 : CTOS_SRC_NORMAL;
   chk_src_from_mode: assert property (!srst && clk_en |=> src_sel == $past(exp_src))
      else $error("source group differs from mode");
   chk_offset_one: assert property (en_st |=> out_pins.a_pos == !$past(angle_octant[2]))
      else $error("channel one offset pin wrong");
   chk_offset_two: assert property (en_st |=> out_pins.b_pos ==
      !($past(angle_octant[2]) ^ $past(angle_octant[1]))) else $error("channel two offset pin wrong");
   chk_phase_dev: assert property (en_st |=> out_pins.a_neg ==
      ($past(angle_octant[1]) ^ $past(angle_octant[0]))) else $error("phase pin wrong");
   chk_amp_dev: assert property (en_st |=> out_pins.b_neg == $past(angle_octant[0]))
      else $error("amplitude pin wrong");
   chk_normal_pass: assert property (!srst && clk_en && exp_src == CTOS_SRC_NORMAL
      |=> out_pins == $past(normal_pins)) else $error("normal pins not passed");
   chk_err_gated: assert property (src_sel == CTOS_SRC_SYSTEST && out_pins.err
      |-> verify_done || $past(verify_done)) else $error("error pin before verify done");
   chk_sincos_mode: assert property (!srst && clk_en
      |=> sincos_current_mode == !$past(sincos_input_resistance[0])) else $error("sincos mode");
   chk_zero_mode: assert property (!srst && clk_en
      |=> zero_current_mode == !$past(zero_input_resistance[0])) else $error("zero mode");
endmodule
bind ctos_top ctos_top_sva #(.ANGLE_W(ANGLE_W), .COUNT_W(COUNT_W)) chk_u (
   .ref_clk, .srst, .clk_en, .mode_select, .sincos_input_resistance, .zero_input_resistance,
   .angle_octant, .normal_pins, .out_pins, .src_sel, .sincos_current_mode, .zero_current_mode,
   .verify_done);

// ---- tb/tb_top.sv ----
// self-checking bench for ctos_top
// assumes ctos_pkg compiled first and the checker bound in its own file
`timescale 1ns/1ps
module tb_top
   import ctos_pkg::*;
;
   logic         ref_clk = 1'b0;
   logic         srst = 1'b1;
   logic         clk_en = 1'b1;
   logic [3:0]   mode_select = 4'h0;
   logic [8:0]   resolution_select = RES_SYSTEST;
   logic [3:0]   hysteresis_select = HYS_SYSTEST;
   logic [7:0]   output_config = 8'h00;
   logic [5:0]   fine_gain_a = 6'h00;
   logic [5:0]   fine_gain_b = 6'h00;
   logic [7:0]   test_option_bits = 8'h00;
   logic [1:0]   input_reference_select = 2'h3;
   logic [3:0]   sincos_input_resistance = 4'h0;
   logic [3:0]   zero_input_resistance = 4'h1;
   logic         index_enable = 1'b0;
   logic [15:0]  lines_per_zero = 16'h0005;
   logic         error_in = 1'b0;
   ctos_pins_t   normal_pins = 7'h55;
   ctos_analog_t analog_in = 13'h0000;
   logic [2:0]   angle_octant;
   logic         zero_pin_raw;
   ctos_pins_t   out_pins;
   ctos_src_t    src_sel;
   logic         systest_setup_ok, input_check_ok, sincos_current_mode, zero_current_mode;
   logic         reference_ok, verify_done, line_count_error;
   logic [2:0]   oct;
   logic [6:0]   got4;
   int           n_errors = 0;
   int           n_compared = 0;
   logic [3:0]   modes [6] = '{MODE_CAL1, MODE_CAL2, MODE_CAL3, MODE_TEST6, 4'h3, MODE_SYSTEST};
   ctos_src_t    srcs [6] = '{CTOS_SRC_CAL1, CTOS_SRC_CAL2, CTOS_SRC_CAL3, CTOS_SRC_TEST6,
                              CTOS_SRC_NORMAL, CTOS_SRC_SYSTEST};
   assign got4 = {3'h0, out_pins.a_pos, out_pins.b_pos, out_pins.a_neg, out_pins.b_neg};
   always #5 ref_clk = ~ref_clk;
   ctos_enc_model #(.LINES(5)) enc_u (.ref_clk, .run(1'b1), .angle_octant, .zero_pin(zero_pin_raw));
   ctos_top #(.ANGLE_W(3), .COUNT_W(16)) dut_u (
      .ref_clk, .srst, .clk_en, .mode_select, .resolution_select, .hysteresis_select,
      .output_config, .fine_gain_a, .fine_gain_b, .test_option_bits, .input_reference_select,
      .sincos_input_resistance, .zero_input_resistance, .index_enable, .lines_per_zero,
      .angle_octant, .zero_pin_raw, .error_in, .normal_pins, .analog_in, .out_pins, .src_sel,
      .systest_setup_ok, .input_check_ok, .sincos_current_mode, .zero_current_mode,
      .reference_ok, .verify_done, .line_count_error);
   // ----------------
   // tasks
   // ----------------
   task automatic wrap_up();
      $display("compared=%0d errors=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk7(input logic [6:0] got, input logic [6:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // which: 0 raw zero, 1 verify done, 2 zero pin out
   task automatic wait_for(input int which, input int lim);
      int k;
      k = 0;
      while (((which == 0) ? zero_pin_raw : (which == 1) ? verify_done : out_pins.z_pos)
             !== 1'b1 && k < lim) begin
         @(posedge ref_clk);
         k++;
      end
      #1;
      if (k >= lim) begin
         n_errors++;
         wrap_up();
      end
   endtask
   // ----------------
   // sequence
   // ----------------
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      settle(1);
      chk7(7'(src_sel), 7'(CTOS_SRC_NORMAL));
      chk1(verify_done, 1'b0);
      @(posedge ref_clk);
      normal_pins <= 7'h2a;
      settle(2);
      chk7(out_pins, 7'h2a);
      @(posedge ref_clk);
      clk_en      <= 1'b0;
      normal_pins <= 7'h15;
      settle(3);
      chk7(out_pins, 7'h2a);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         mode_select <= modes[i];
         settle(2);
         chk7(7'(src_sel), 7'(srcs[i]));
      end
      chk1(systest_setup_ok, 1'b1);
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         oct = angle_octant;
         #1;
         chk7(got4, {3'h0, ~oct[2], ~(oct[2] ^ oct[1]), oct[1] ^ oct[0], oct[0]});
      end
      @(posedge ref_clk);
      output_config <= 8'h10;
      settle(2);
      chk1(systest_setup_ok, 1'b0);
      @(posedge ref_clk);
      output_config <= 8'h00;
      index_enable  <= 1'b1;
      error_in      <= 1'b1;
      settle(2);
      chk1(out_pins.err, 1'b0);
      wait_for(0, 200);
      chk1(out_pins.z_pos, 1'b0);
      wait_for(2, 10);
      chk1(out_pins.z_pos, 1'b1);
      settle(20);
      chk1(verify_done, 1'b0);
      chk1(out_pins.err, 1'b0);
      wait_for(1, 400);
      settle(2);
      chk1(out_pins.z_neg, 1'b1);
      chk1(line_count_error, 1'b0);
      chk1(out_pins.err, 1'b1);
      @(posedge ref_clk);
      error_in <= 1'b0;
      settle(2);
      chk1(out_pins.err, 1'b0);
      @(posedge ref_clk);
      mode_select    <= 4'h0;
      lines_per_zero <= 16'h0007;
      settle(2);
      chk1(verify_done, 1'b0);
      @(posedge ref_clk);
      mode_select <= MODE_SYSTEST;
      wait_for(1, 500);
      settle(2);
      chk1(line_count_error, 1'b1);
      chk1(out_pins.err, 1'b1);
      @(posedge ref_clk);
      mode_select      <= MODE_TEST6;
      test_option_bits <= 8'h08;
      settle(2);
      chk1(input_check_ok, 1'b1);
      @(posedge ref_clk);
      test_option_bits <= 8'h18;
      settle(2);
      chk1(input_check_ok, 1'b0);
      @(posedge ref_clk);
      test_option_bits <= 8'h08;
      fine_gain_a      <= 6'h01;
      settle(2);
      chk1(input_check_ok, 1'b0);
      chk1(sincos_current_mode, 1'b1);
      chk1(zero_current_mode, 1'b0);
      chk1(reference_ok, 1'b0);
      @(posedge ref_clk);
      sincos_input_resistance <= 4'h9;
      zero_input_resistance   <= 4'h6;
      input_reference_select  <= 2'h0;
      settle(2);
      chk1(sincos_current_mode, 1'b0);
      chk1(zero_current_mode, 1'b1);
      chk1(reference_ok, 1'b1);
      wrap_up();
   end
endmodule
